// >>> logic/scrb_pkg.sv
`default_nettype none
package scrb_pkg;
   localparam int CLK_HZ         = 25_000_000;
   localparam int HB_PERIOD_S    = 1;
   localparam int SEC_CYCLES     = CLK_HZ * HB_PERIOD_S;
   localparam int HB_SILENCE_DEF = 2;
   localparam int IDX_LSB        = 2;
   localparam int IDX_MSB        = 17;

   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_EXT_ID   = 16'h9CC9;
   localparam logic [15:0] IDX_EXT_LEN  = 16'h9CCA;
   localparam logic [15:0] IDX_LOCAL    = 16'h9CCB;
   localparam logic [15:0] IDX_SUP_HB   = 16'h9CCC;
   localparam logic [15:0] IDX_HOST_HB  = 16'h9CCD;
   localparam logic [15:0] IDX_FLT_CLR  = 16'h9CCE;
   localparam logic [15:0] IDX_OP_CMD   = 16'h9CCF;
   localparam logic [15:0] IDX_CTRL_ID  = 16'h9CD3;
   localparam logic [15:0] IDX_CTRL_LEN = 16'h9CD4;
   localparam logic [15:0] IDX_MODE     = 16'h9CD5;
   localparam logic [15:0] IDX_AC_RATE  = 16'h9CD6;
   localparam logic [15:0] IDX_V_SET    = 16'h9CD7;
   localparam logic [15:0] IDX_V_UPPER  = 16'h9CD8;
   localparam logic [15:0] IDX_V_LOWER  = 16'h9CD9;
   localparam logic [15:0] IDX_V_BOOT   = 16'h9CDA;
   localparam logic [15:0] IDX_V_SLEW   = 16'h9CDB;
   localparam logic [15:0] IDX_DROOP    = 16'h9CDC;
   localparam logic [15:0] IDX_I_SET    = 16'h9CDD;
   localparam logic [15:0] IDX_I_MAX    = 16'h9CDE;
   localparam logic [15:0] IDX_I_MIN    = 16'h9CDF;

   localparam logic [15:0] EXT_LENGTH   = 16'h0008;
   localparam logic [15:0] CTRL_LENGTH  = 16'h0028;
   localparam logic [15:0] AC_RATING    = 16'h0FA0;
   localparam logic [15:0] V_MAX        = 16'h2008;
   localparam logic [15:0] V_UPPER_RST  = 16'h2008;
   localparam logic [15:0] V_LOWER_RST  = 16'h0000;
   localparam logic [15:0] V_BOOT_RST   = 16'h1770;
   localparam logic [15:0] V_SET_RST    = 16'h0000;
   localparam logic [15:0] SLEW_RST     = 16'h2710;
   localparam logic [15:0] SLEW_MIN     = 16'h0001;
   localparam logic [15:0] SLEW_MAX     = 16'h4E20;
   localparam logic [15:0] DROOP_RST    = 16'h00FA;
   localparam logic [15:0] DROOP_MAX    = 16'h1388;
   localparam logic [15:0] HB_RST       = 16'h0000;
   localparam logic [15:0] MODE_MAX     = 16'h0002;
   localparam logic [15:0] FLT_CLR_VAL  = 16'h0001;
   localparam logic [15:0] OP_CONNECT   = 16'h0001;
   localparam logic [15:0] OP_DISCON    = 16'h0002;
   localparam logic [15:0] OP_STANDBY   = 16'h0003;
   localparam logic [15:0] OP_RUN       = 16'h0004;
   localparam logic signed [15:0] I_LIM_HI  = 16'sh02EE;
   localparam logic signed [15:0] I_LIM_LO  = 16'shFD12;
   localparam logic signed [15:0] I_SET_RST = 16'sh0000;

   typedef enum logic [1:0] {
      SCRB_MODE_VOLTAGE,
      SCRB_MODE_CURRENT,
      SCRB_MODE_POWER
   } scrb_mode_t;
endpackage
`default_nettype wire

// >>> logic/scrb_tick.sv
`timescale 1ns/10ps
`default_nettype none
module scrb_tick import scrb_pkg::*; #(
   parameter int DIV = SEC_CYCLES
) (
   input  wire logic clk,
   input  wire logic rst_n,
   output logic      tick
);
   // DIV must be at least 2
   localparam int W = $clog2(DIV);

   logic [W-1:0] cnt;
   wire          wrap = (cnt == W'(DIV - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt  <= '0;
         tick <= 1'b0;
      end else begin
         tick <= wrap;
         cnt  <= wrap ? '0 : W'(cnt + 1'b1);
      end
   end
endmodule
`default_nettype wire

// >>> logic/scrb_ramp.sv
`timescale 1ns/10ps
`default_nettype none
module scrb_ramp import scrb_pkg::*; #(
   parameter int RATE_HZ = CLK_HZ
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] target,
   input  wire logic [15:0] rate,
   output logic      [15:0] level
);
   // fractional accumulator: one unit step each time rate sums past the clock rate
   localparam int AW = $clog2(RATE_HZ + 65536) + 1;

   logic [AW-1:0] acc;
   wire  [AW-1:0] sum    = AW'(acc + AW'(rate));
   wire           step   = (sum >= AW'(RATE_HZ));
   wire           moving = (level != target);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc   <= '0;
         level <= V_SET_RST;
      end else if (!moving) begin
         acc <= '0;
      end else if (step) begin
         acc   <= AW'(sum - AW'(RATE_HZ));
         level <= (level < target) ? 16'(level + 16'h0001) : 16'(level - 16'h0001);
      end else begin
         acc <= sum;
      end
   end
endmodule
`default_nettype wire

// >>> logic/scrb_bank.sv
// Notes on behaviour
// - headers report eight and forty following registers
// - supply heartbeat increments every second, wrapping
// - missed host heartbeat raises a fault
// - heartbeat timeout armed by first host write
// - writing one clears faults; reads back zero
// - command 1 connects, 2 disconnects contactor
// - command 3 standby, 4 run; self-clears
// - mode 0 voltage, 1 current, 2 power
// - AC power rating reads 4000
// - upper voltage limit 0..8200, default 8200
// - lower voltage limit 0..8200, default 0
// - setpoint loads power-on default after reset
// - setpoint changes ramp at slew rate
// - droop 0..5000 mohm, zero disables droop
// - current setpoint bounded by current limits
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module scrb_bank import scrb_pkg::*; #(
   parameter int          TICK_CYCLES   = SEC_CYCLES,
   parameter int          HB_SILENCE    = HB_SILENCE_DEF,
   parameter logic [15:0] EXT_MODEL_ID  = 16'hA5C1, // arbitrary value
   parameter logic [15:0] CTRL_MODEL_ID = 16'hA5C2  // arbitrary value
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [IDX_MSB:0]     paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 local_panel_pin,
   output logic                      heartbeat_fault,
   output logic                      fault_clear_pulse,
   output logic                      connect_req,
   output logic                      disconnect_req,
   output logic                      standby_req,
   output logic                      run_req,
   output scrb_mode_t                regulation_mode,
   output logic      [15:0]          voltage_target,
   output logic      [15:0]          droop_resistance_mohm,
   output logic                      droop_enable,
   output logic signed [15:0]        current_target
);
   localparam int SW = $clog2(HB_SILENCE + 1);

   logic              loc_meta;
   logic              loc_sync;
   logic              tick;
   logic              err_q;
   logic              boot_pending;
   logic              hb_armed;
   logic [SW-1:0]     hb_silence;
   logic [15:0]       hb_supply;
   logic [15:0]       hb_host;
   logic [15:0]       v_set;
   logic [15:0]       v_upper;
   logic [15:0]       v_lower;
   logic [15:0]       v_boot;
   logic [15:0]       v_slew;
   logic signed [15:0] i_max;
   logic signed [15:0] i_min;

   // ---------------- APB decode ----------------
   wire [15:0]        idx     = paddr[IDX_MSB:IDX_LSB];
   wire [15:0]        wd      = pwdata[15:0];
   wire signed [15:0] wds     = pwdata[15:0];
   wire               setup   = psel & ~penable;
   wire               wr_fire = psel & penable & pwrite & ~err_q;
   wire               mapped  = (idx >= IDX_EXT_ID && idx <= IDX_OP_CMD) ||
                                (idx >= IDX_CTRL_ID && idx <= IDX_I_MIN);

   wire we_hb    = wr_fire & (idx == IDX_HOST_HB);
   wire we_flt   = wr_fire & (idx == IDX_FLT_CLR);
   wire we_op    = wr_fire & (idx == IDX_OP_CMD);
   wire we_mode  = wr_fire & (idx == IDX_MODE);
   wire we_vset  = wr_fire & (idx == IDX_V_SET);
   wire we_vup   = wr_fire & (idx == IDX_V_UPPER);
   wire we_vlo   = wr_fire & (idx == IDX_V_LOWER);
   wire we_vboot = wr_fire & (idx == IDX_V_BOOT);
   wire we_slew  = wr_fire & (idx == IDX_V_SLEW);
   wire we_droop = wr_fire & (idx == IDX_DROOP);
   wire we_iset  = wr_fire & (idx == IDX_I_SET);
   wire we_imax  = wr_fire & (idx == IDX_I_MAX);
   wire we_imin  = wr_fire & (idx == IDX_I_MIN);

   // limits may not cross each other or the live setpoints, so a setpoint
   // already accepted never ends up outside its window; a setup in the boot
   // cycle is judged against the default that is about to load
   wire [15:0] v_set_eff = boot_pending ? v_boot : v_set;
   wire wr_ok =
      (idx == IDX_HOST_HB) ? 1'b1 :
      (idx == IDX_FLT_CLR) ? (wd <= FLT_CLR_VAL) :
      (idx == IDX_OP_CMD)  ? (wd <= OP_RUN) :
      (idx == IDX_MODE)    ? (wd <= MODE_MAX) :
      (idx == IDX_V_SET)   ? (wd <= v_upper && wd >= v_lower) :
      (idx == IDX_V_UPPER) ? (wd <= V_MAX && wd >= v_lower && wd >= v_set_eff) :
      (idx == IDX_V_LOWER) ? (wd <= v_upper && wd <= v_set_eff) :
      (idx == IDX_V_BOOT)  ? (wd <= V_MAX) :
      (idx == IDX_V_SLEW)  ? (wd >= SLEW_MIN && wd <= SLEW_MAX) :
      (idx == IDX_DROOP)   ? (wd <= DROOP_MAX) :
      (idx == IDX_I_SET)   ? (wds <= i_max && wds >= i_min) :
      (idx == IDX_I_MAX)   ? (wds <= I_LIM_HI && wds >= i_min && wds >= current_target) :
      (idx == IDX_I_MIN)   ? (wds >= I_LIM_LO && wds <= i_max && wds <= current_target) :
      1'b0;

   // command registers clear themselves, so they always read as zero
   wire [15:0] rd_val =
      (idx == IDX_EXT_ID)   ? EXT_MODEL_ID :
      (idx == IDX_EXT_LEN)  ? EXT_LENGTH :
      (idx == IDX_LOCAL)    ? 16'(loc_sync) :
      (idx == IDX_SUP_HB)   ? hb_supply :
      (idx == IDX_HOST_HB)  ? hb_host :
      (idx == IDX_CTRL_ID)  ? CTRL_MODEL_ID :
      (idx == IDX_CTRL_LEN) ? CTRL_LENGTH :
      (idx == IDX_MODE)     ? 16'(regulation_mode) :
      (idx == IDX_AC_RATE)  ? AC_RATING :
      (idx == IDX_V_SET)    ? v_set :
      (idx == IDX_V_UPPER)  ? v_upper :
      (idx == IDX_V_LOWER)  ? v_lower :
      (idx == IDX_V_BOOT)   ? v_boot :
      (idx == IDX_V_SLEW)   ? v_slew :
      (idx == IDX_DROOP)    ? droop_resistance_mohm :
      (idx == IDX_I_SET)    ? current_target :
      (idx == IDX_I_MAX)    ? i_max :
      (idx == IDX_I_MIN)    ? i_min :
      16'h0000;

   // zero wait states; answer captured in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = psel & penable & err_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         err_q  <= 1'b0;
      end else if (setup) begin
         prdata <= {16'h0000, rd_val};
         err_q  <= pwrite ? ~(mapped & wr_ok) : ~mapped;
      end
   end

   // ---------------- local panel pin ----------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loc_meta <= 1'b0;
         loc_sync <= 1'b0;
      end else begin
         loc_meta <= local_panel_pin;
         loc_sync <= loc_meta;
      end
   end

   // ---------------- heartbeats ----------------
   scrb_tick #(
      .DIV (TICK_CYCLES)
   ) u_tick (
      .clk   (pclk),
      .rst_n (presetn),
      .tick  (tick)
   );

   // once armed, a beat only counts if it steps the value by one or restarts at zero
   wire hb_valid = we_hb & (~hb_armed | wd == 16'(hb_host + 16'h0001) | wd == HB_RST);
   wire flt_clr  = we_flt & (wd == FLT_CLR_VAL);
   wire hb_set   = tick & hb_armed & ~hb_valid & (hb_silence == SW'(HB_SILENCE - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hb_supply <= HB_RST;
      end else if (tick) begin
         hb_supply <= 16'(hb_supply + 16'h0001);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hb_host  <= HB_RST;
         hb_armed <= 1'b0;
      end else if (we_hb) begin
         hb_host  <= wd;
         hb_armed <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hb_silence <= '0;
      end else if (hb_valid || flt_clr) begin
         hb_silence <= '0;
      end else if (tick && hb_armed && hb_silence != SW'(HB_SILENCE)) begin
         hb_silence <= SW'(hb_silence + 1'b1);
      end
   end

   // a timeout in the same cycle as a clear still latches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         heartbeat_fault <= 1'b0;
      end else begin
         heartbeat_fault <= hb_set | (heartbeat_fault & ~flt_clr);
      end
   end

   // ---------------- self-clearing commands ----------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_clear_pulse <= 1'b0;
         connect_req       <= 1'b0;
         disconnect_req    <= 1'b0;
         standby_req       <= 1'b0;
         run_req           <= 1'b0;
      end else begin
         fault_clear_pulse <= flt_clr;
         connect_req       <= we_op & (wd == OP_CONNECT);
         disconnect_req    <= we_op & (wd == OP_DISCON);
         standby_req       <= we_op & (wd == OP_STANDBY);
         run_req           <= we_op & (wd == OP_RUN);
      end
   end

   // ---------------- configuration ----------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         regulation_mode <= SCRB_MODE_VOLTAGE;
      end else if (we_mode) begin
         regulation_mode <= scrb_mode_t'(wd[1:0]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         v_upper <= V_UPPER_RST;
         v_lower <= V_LOWER_RST;
         v_boot  <= V_BOOT_RST;
         v_slew  <= SLEW_RST;
      end else begin
         if (we_vup)   v_upper <= wd;
         if (we_vlo)   v_lower <= wd;
         if (we_vboot) v_boot  <= wd;
         if (we_slew)  v_slew  <= wd;
      end
   end

   // the setpoint takes the stored power-on default one cycle after release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_pending <= 1'b1;
         v_set        <= V_SET_RST;
      end else begin
         boot_pending <= 1'b0;
         if (boot_pending) begin
            v_set <= v_boot;
         end else if (we_vset) begin
            v_set <= wd;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         droop_resistance_mohm <= DROOP_RST;
         droop_enable          <= 1'b1;
      end else if (we_droop) begin
         droop_resistance_mohm <= wd;
         droop_enable          <= (wd != 16'h0000);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         current_target <= I_SET_RST;
         i_max          <= I_LIM_HI;
         i_min          <= I_LIM_LO;
      end else begin
         if (we_iset) current_target <= wds;
         if (we_imax) i_max          <= wds;
         if (we_imin) i_min          <= wds;
      end
   end

   // output limited to one 0.1 V step per 1/slew seconds
   scrb_ramp #(
      .RATE_HZ (CLK_HZ)
   ) u_ramp (
      .clk    (pclk),
      .rst_n  (presetn),
      .target (v_set),
      .rate   (v_slew),
      .level  (voltage_target)
   );

   // ---------------- checks ----------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_ext_length: assert property (setup && idx == IDX_EXT_LEN |=> prdata == 32'h0000_0008)
      else $error("extension model length not eight");
   a_ctrl_length: assert property (setup && idx == IDX_CTRL_LEN |=> prdata == 32'h0000_0028)
      else $error("control model length not forty");
   a_supply_beat: assert property (tick |=> hb_supply == 16'($past(hb_supply) + 16'h0001))
      else $error("supply heartbeat did not step on tick");
   a_hb_timeout: assert property (hb_set |=> heartbeat_fault)
      else $error("heartbeat timeout not latched");
   a_hb_disarmed: assert property (!hb_armed |-> !heartbeat_fault && hb_silence == '0)
      else $error("heartbeat fault while disarmed");
   a_fault_clear: assert property (flt_clr && !hb_set |=> fault_clear_pulse && !heartbeat_fault
                                   ##1 !fault_clear_pulse)
      else $error("fault clear did not act for one cycle");
   a_op_connect: assert property (we_op && wd == OP_CONNECT |=> connect_req && !run_req
                                  ##1 !connect_req)
      else $error("connect request not a single pulse");
   a_op_run: assert property (we_op && wd == OP_RUN |=> run_req && !standby_req ##1 !run_req)
      else $error("run request not a single pulse");
   a_mode_reject: assert property (psel && penable && pwrite && idx == IDX_MODE && wd > MODE_MAX
                                   |-> pslverr ##1 $stable(regulation_mode))
      else $error("illegal mode accepted");
   a_rating: assert property (setup && idx == IDX_AC_RATE |=> prdata[15:0] == 16'h0FA0)
      else $error("AC power rating wrong");
   a_vset_window: assert property (!boot_pending |-> v_set <= v_upper && v_set >= v_lower
                                   && v_upper <= V_MAX)
      else $error("voltage setpoint outside limits");
   a_boot_load: assert property (boot_pending |=> v_set == $past(v_boot) && !boot_pending)
      else $error("power-on default not loaded");
   a_ramp_step: assert property ($changed(voltage_target) |->
                                 voltage_target == 16'($past(voltage_target) + 16'h0001) ||
                                 voltage_target == 16'($past(voltage_target) - 16'h0001))
      else $error("voltage ramp jumped");
   a_droop_off: assert property (we_droop && wd == 16'h0000 |=> !droop_enable)
      else $error("zero droop did not disable droop");
   a_cur_window: assert property (current_target <= i_max && current_target >= i_min)
      else $error("current setpoint outside limits");
   a_reject_keep: assert property (psel && penable && pwrite && err_q && idx == IDX_V_SET
                                   |-> pslverr ##1 $stable(v_set))
      else $error("rejected write changed setpoint");
   a_beat_refresh: assert property (hb_valid |=> hb_silence == '0)
      else $error("valid beat did not restart silence count");

   c_timeout: cover property ($rose(heartbeat_fault));
   c_run: cover property (run_req);
   c_ramp_done: cover property (!boot_pending && voltage_target == v_set && v_set != 16'h0000);
   c_reject: cover property (pslverr);
endmodule
`default_nettype wire

// >>> verification/scrb_host.sv
`timescale 1ns/10ps
`default_nettype none
module scrb_host import scrb_pkg::*; (
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [31:0] prdata,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [17:0] paddr,
   output logic      [31:0] pwdata
);
   logic [15:0] hb_next;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      hb_next = 16'h0000;
   end
   // the answer is taken at the rising edge where pready is sampled high, never later
   task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d,
                       output logic [31:0] rd, output logic er, output logic to);
      to = 1'b1;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (int i = 0; i < 16 && to; i++) begin
         @(posedge pclk);
         // values read here are what this edge sampled; design updates are still pending
         if (pready === 1'b1) begin
            rd = prdata;
            er = pslverr;
            to = 1'b0;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines change so stale values are never mistaken for a request
      paddr <= ~paddr;
      pwdata <= ~pwdata;
   endtask
   task automatic beat(output logic er, output logic to);
      logic [31:0] rd;
      xfer(1'b1, IDX_HOST_HB, {16'h0000, hb_next}, rd, er, to);
      hb_next = hb_next + 16'h0001;
   endtask
endmodule
`default_nettype wire

// >>> verification/supply_control_register_bank_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("Error %s exp %h got %h", nm, e, g); end end
module supply_control_register_bank_tb import scrb_pkg::*;;
   logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        [17:0] paddr;
   logic        [31:0] pwdata, prdata;
   logic               local_panel_pin, heartbeat_fault, fault_clear_pulse;
   logic               connect_req, disconnect_req, standby_req, run_req, droop_enable;
   scrb_mode_t         regulation_mode;
   logic        [15:0] voltage_target, droop_resistance_mohm;
   logic signed [15:0] current_target;
   int                 num_errors, n_checks;
   int                 seed = 32'hB1C4;
   localparam logic [15:0] RI [16] = '{IDX_EXT_ID, IDX_EXT_LEN, IDX_LOCAL, IDX_CTRL_ID,
      IDX_CTRL_LEN, IDX_MODE, IDX_AC_RATE, IDX_V_SET, IDX_V_UPPER, IDX_V_LOWER, IDX_V_BOOT,
      IDX_V_SLEW, IDX_DROOP, IDX_I_SET, IDX_I_MAX, IDX_I_MIN};
   localparam logic [15:0] RV [16] = '{16'hA5C1, 16'h0008, 16'h0000, 16'hA5C2, 16'h0028,
      16'h0000, 16'h0FA0, 16'h1770, 16'h2008, 16'h0000, 16'h1770, 16'h2710, 16'h00FA,
      16'h0000, 16'h02EE, 16'hFD12};
   scrb_bank #(.TICK_CYCLES(20), .HB_SILENCE(2)) u_scrb_bank (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .local_panel_pin,
      .heartbeat_fault, .fault_clear_pulse, .connect_req, .disconnect_req, .standby_req,
      .run_req, .regulation_mode, .voltage_target, .droop_resistance_mohm, .droop_enable,
      .current_target);
   scrb_host u_scrb_host (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite,
      .paddr, .pwdata);
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   function automatic logic droop_bad(input logic [15:0] v);
      return v > DROOP_MAX;
   endfunction
   task automatic acc(input logic w, input logic [15:0] idx, input logic [31:0] d,
                      input logic xe, input logic [31:0] xr);
      logic [31:0] rd;
      logic        er, to;
      u_scrb_host.xfer(w, idx, d, rd, er, to);
      if (to) begin
         num_errors++;
         wrap_up();
      end else begin
         `CHK("pslverr", xe, er)
         if (!w && !xe) `CHK("prdata", xr, rd)
      end
   endtask
   task automatic hb(input int n);
      logic er, to;
      u_scrb_host.beat(er, to);
      if (to) begin
         num_errors++;
         wrap_up();
      end
      `CHK("hb_err", 1'b0, er)
      repeat (n) @(posedge pclk);
   endtask
   initial begin
      logic [31:0] h0;
      logic [15:0] d;
      logic        er, to;
      presetn = 1'b0;
      local_panel_pin = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      // the slowest check first: one ramp step at the default slew takes 2500 cycles
      repeat (2600) @(posedge pclk);
      @(negedge pclk);
      `CHK("vtarget", 16'h0001, voltage_target)
      `CHK("hbfault", 1'b0, heartbeat_fault)
      for (int i = 0; i < 16; i++) acc(0, RI[i], 0, 0, {16'h0, RV[i]});
      acc(1, IDX_AC_RATE, 5, 1, 0);
      acc(1, IDX_EXT_LEN, 9, 1, 0);
      acc(0, 16'h9CD0, 0, 1, 0);
      $display("test reset done");
      for (int k = 1; k <= 4; k++) begin
         acc(1, IDX_OP_CMD, k, 0, 0);
         @(negedge pclk);
         `CHK("op", 4'(1 << (k - 1)), {run_req, standby_req, disconnect_req, connect_req})
         @(negedge pclk);
         `CHK("op_end", 4'h0, {run_req, standby_req, disconnect_req, connect_req})
      end
      acc(0, IDX_OP_CMD, 0, 0, 0);
      acc(1, IDX_OP_CMD, 5, 1, 0);
      for (int k = 0; k <= 3; k++) begin
         acc(1, IDX_MODE, k, k == 3, 0);
         @(negedge pclk);
         `CHK("mode", scrb_mode_t'(k == 3 ? 2 : k), regulation_mode)
      end
      $display("test ops done");
      acc(1, IDX_V_SET, 8300, 1, 0);
      acc(1, IDX_V_UPPER, 4000, 1, 0);
      acc(1, IDX_V_LOWER, 7000, 1, 0);
      acc(1, IDX_V_UPPER, 7000, 0, 0);
      acc(1, IDX_V_SET, 7001, 1, 0);
      acc(1, IDX_V_SET, 7000, 0, 0);
      acc(0, IDX_V_SET, 0, 0, 7000);
      acc(1, IDX_V_BOOT, 8201, 1, 0);
      acc(1, IDX_V_SLEW, 0, 1, 0);
      acc(1, IDX_V_SLEW, 20001, 1, 0);
      acc(1, IDX_I_SET, 751, 1, 0);
      acc(1, IDX_I_SET, 32'hFD12, 0, 0);
      @(negedge pclk);
      `CHK("itarget", I_LIM_LO, current_target)
      acc(1, IDX_I_SET, 32'hFD11, 1, 0);
      for (int k = 0; k < 8; k++) begin
         d = (k == 0) ? 16'h0000 : (k == 1) ? 16'h1389 : (k == 2) ? 16'h1388
            : 16'($unsigned($random(seed)) % 6000);
         acc(1, IDX_DROOP, d, droop_bad(d), 0);
         @(negedge pclk);
         if (!droop_bad(d)) `CHK("droop", d, droop_resistance_mohm)
         if (!droop_bad(d)) `CHK("droop_en", d != 0, droop_enable)
      end
      @(posedge pclk);
      local_panel_pin <= 1'b1;
      repeat (3) @(posedge pclk);
      acc(0, IDX_LOCAL, 0, 0, 1);
      $display("test limits done");
      u_scrb_host.xfer(0, IDX_SUP_HB, 0, h0, er, to);
      if (to) begin
         num_errors++;
         wrap_up();
      end
      // 57 idle plus 3 bus cycles puts the two samples exactly three ticks apart
      repeat (57) @(posedge pclk);
      acc(0, IDX_SUP_HB, 0, 0, {16'h0, 16'(h0[15:0] + 16'h0003)});
      `CHK("hbfault", 1'b0, heartbeat_fault)
      hb(15);
      `CHK("hbfault", 1'b0, heartbeat_fault)
      repeat (30) @(posedge pclk);
      `CHK("hbfault", 1'b1, heartbeat_fault)
      acc(1, IDX_FLT_CLR, 1, 0, 0);
      @(negedge pclk);
      `CHK("clr_pulse", 1'b1, fault_clear_pulse)
      @(negedge pclk);
      `CHK("hbfault", 1'b0, heartbeat_fault)
      for (int k = 0; k < 6; k++) hb(12);
      `CHK("hbfault", 1'b0, heartbeat_fault)
      acc(0, IDX_HOST_HB, 0, 0, 32'h0000_0006);
      acc(0, IDX_FLT_CLR, 0, 0, 0);
      acc(1, IDX_FLT_CLR, 2, 1, 0);
      $display("test heartbeat done");
      wrap_up();
   end
endmodule
`default_nettype wire
